// ---- logic/cbt_pkg.sv ----
// Constants, register map and types for the CAN bit timing, interrupt mask and timer block
package cbt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_OBJ_EN     = 8'hDE;
  localparam logic [7:0] IDX_OBJ_STAT   = 8'hE0;
  localparam logic [7:0] IDX_BT_PRESC   = 8'hE2;
  localparam logic [7:0] IDX_BT_JMPPRP  = 8'hE3;
  localparam logic [7:0] IDX_BT_PHASE   = 8'hE4;
  localparam logic [7:0] IDX_TMR_PRESC  = 8'hE5;
  localparam logic [7:0] IDX_TMR_COUNT  = 8'hE6;
  localparam logic [7:0] IDX_TRIG_CAPT  = 8'hE8;
  localparam logic [7:0] IDX_EVT_STAT   = 8'hF0;
  localparam logic [7:0] IDX_EVT_MASK   = 8'hF1;
  localparam logic [7:0] IDX_TOP_OBJ    = 8'hF2;

  // Field positions
  localparam int BRP_LSB   = 1;
  localparam int SJW_LSB   = 5;
  localparam int PRS_LSB   = 1;
  localparam int PHASE_SEGMENT_TWO_LSB  = 4;
  localparam int PHASE_SEGMENT_ONE_LSB  = 1;
  localparam int SMP_BIT   = 0;
  localparam int EVT_WRAP  = 0;
  localparam int EVT_OBJ   = 1;

  // Values after reset
  localparam logic [5:0]  RST_OBJ_EN  = 6'h00;
  localparam logic [5:0]  RST_BRP     = 6'h00;
  localparam logic [1:0]  RST_SJW     = 2'h0;
  localparam logic [2:0]  RST_SEG     = 3'h0;
  localparam logic [7:0]  RST_TDIV    = 8'h00;
  localparam logic [15:0] RST_COUNT   = 16'h0000;
  localparam logic [1:0]  RST_EVT     = 2'h0;
  localparam logic [3:0]  RST_SEG_END = 4'h1;

  // Timer clock is the I/O clock over eight times (divider plus one)
  localparam logic [2:0]  TMR_DIV_LOW = 3'h7;
  localparam logic [15:0] TMR_MAX     = 16'hFFFF;
  localparam logic [3:0]  NO_OBJECT   = 4'hF;

  // Bit segments
  typedef enum logic [1:0] {
    SEG_SYNC = 2'b00,
    SEG_PROP = 2'b01,
    SEG_PH1  = 2'b10,
    SEG_PH2  = 2'b11
  } cbt_seg_t;

endpackage

// ---- logic/cbt_core.sv ----
// CAN bit timing, per-object interrupt masks, bus timer and capture, APB slave
`timescale 1ns/100ps

module cbt_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ctrl_enable,
  input  wire logic [5:0]  obj_irq_src,
  input  wire logic        rx_bus,
  input  wire logic        capture_strobe,
  output logic             obj_irq,
  output logic      [3:0]  top_priority_object,
  output logic             timer_wrap_flag,
  output logic             sample_pulse,
  output logic             sampled_bit,
  output logic             irq
);

  logic [31:0]      prdata_r;
  logic             pready_r;
  logic             pslverr_r;
  logic [5:0]       obj_en_r;
  logic [5:0]       obj_stat_r;
  logic             obj_irq_r;
  logic [3:0]       top_obj_r;
  logic [5:0]       brp_r;
  logic [1:0]       sjw_r;
  logic [2:0]       prs_r;
  logic [2:0]       phase_segment_two_r;
  logic [2:0]       phase_segment_one_r;
  logic             smp_r;
  logic [7:0]       tdiv_r;
  logic [15:0]      timer_r;
  logic [15:0]      capt_r;
  logic [1:0]       evt_r;
  logic [1:0]       evt_nxt;
  logic [1:0]       mask_r;
  logic             irq_r;
  logic             rx_s1;
  logic             rx_s2;
  logic             rx_prev;
  logic [1:0]       rx_hist_r;
  logic [5:0]       tq_cnt_r;
  logic             tq_tick;
  cbt_pkg::cbt_seg_t state_r;
  logic [3:0]       seg_cnt_r;
  logic [3:0]       ph1_end_r;
  logic [3:0]       ph2_end_r;
  logic             resynced_r;
  logic             resync_ok;
  logic [3:0]       sjw1;
  logic [4:0]       phase_err;
  logic [3:0]       ext;
  logic [3:0]       ph2_left;
  logic             sample_now;
  logic             majority;
  logic             sample_pulse_r;
  logic             sampled_bit_r;
  logic [10:0]      tdiv_cnt_r;
  logic             tmr_tick;
  logic             wrap_evt;
  logic             wr_en;
  logic             rd_en;
  logic [31:0]      rd_mux;
  logic             mapped;

  // Register hit: word aligned and inside the first 1 KiB of the 4 KiB window
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[11:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
  endfunction

  // Lowest object index has the top priority
  function automatic logic [3:0] top_obj(input logic [5:0] s);
    top_obj = cbt_pkg::NO_OBJECT;
    for (int i = 5; i >= 0; i--) begin
      if (s[i]) begin
        top_obj = 4'(i);
      end
    end
  endfunction

  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = pslverr_r;
  assign obj_irq             = obj_irq_r;
  assign top_priority_object = top_obj_r;
  assign timer_wrap_flag     = evt_r[cbt_pkg::EVT_WRAP];
  assign sample_pulse        = sample_pulse_r;
  assign sampled_bit         = sampled_bit_r;
  assign irq                 = irq_r;

  // One wait state keeps read data and error straight from flops
  assign wr_en = psel & penable & pwrite & pready_r;
  assign rd_en = psel & penable & ~pready_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= rd_en;
      prdata_r  <= rd_en ? rd_mux : 32'h0000_0000;
      pslverr_r <= rd_en & ~mapped;
    end
  end

  // Read mux; reserved bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    if (hit(paddr, cbt_pkg::IDX_OBJ_EN)) begin
      rd_mux[5:0] = obj_en_r;
    end else if (hit(paddr, cbt_pkg::IDX_OBJ_STAT)) begin
      rd_mux[5:0] = obj_stat_r;
    end else if (hit(paddr, cbt_pkg::IDX_BT_PRESC)) begin
      rd_mux[cbt_pkg::BRP_LSB +: 6] = brp_r;
    end else if (hit(paddr, cbt_pkg::IDX_BT_JMPPRP)) begin
      rd_mux[cbt_pkg::SJW_LSB +: 2] = sjw_r;
      rd_mux[cbt_pkg::PRS_LSB +: 3] = prs_r;
    end else if (hit(paddr, cbt_pkg::IDX_BT_PHASE)) begin
      rd_mux[cbt_pkg::PHASE_SEGMENT_TWO_LSB +: 3] = phase_segment_two_r;
      rd_mux[cbt_pkg::PHASE_SEGMENT_ONE_LSB +: 3] = phase_segment_one_r;
      rd_mux[cbt_pkg::SMP_BIT]       = smp_r;
    end else if (hit(paddr, cbt_pkg::IDX_TMR_PRESC)) begin
      rd_mux[7:0] = tdiv_r;
    end else if (hit(paddr, cbt_pkg::IDX_TMR_COUNT)) begin
      rd_mux[15:0] = timer_r;
    end else if (hit(paddr, cbt_pkg::IDX_TRIG_CAPT)) begin
      rd_mux[15:0] = capt_r;
    end else if (hit(paddr, cbt_pkg::IDX_EVT_STAT)) begin
      rd_mux[1:0] = evt_r;
    end else if (hit(paddr, cbt_pkg::IDX_EVT_MASK)) begin
      rd_mux[1:0] = mask_r;
    end else if (hit(paddr, cbt_pkg::IDX_TOP_OBJ)) begin
      rd_mux[3:0] = top_obj_r;
    end else begin
      mapped = 1'b0;
    end
  end

  // Configuration writes; read-only and unmapped writes have no effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      obj_en_r <= cbt_pkg::RST_OBJ_EN;
      brp_r    <= cbt_pkg::RST_BRP;
      sjw_r    <= cbt_pkg::RST_SJW;
      prs_r    <= cbt_pkg::RST_SEG;
      phase_segment_two_r   <= cbt_pkg::RST_SEG;
      phase_segment_one_r   <= cbt_pkg::RST_SEG;
      smp_r    <= 1'b0;
      tdiv_r   <= cbt_pkg::RST_TDIV;
      mask_r   <= cbt_pkg::RST_EVT;
    end else if (wr_en) begin
      if (hit(paddr, cbt_pkg::IDX_OBJ_EN)) begin
        obj_en_r <= pwdata[5:0];
      end
      if (hit(paddr, cbt_pkg::IDX_BT_PRESC)) begin
        brp_r <= pwdata[cbt_pkg::BRP_LSB +: 6];
      end
      if (hit(paddr, cbt_pkg::IDX_BT_JMPPRP)) begin
        sjw_r <= pwdata[cbt_pkg::SJW_LSB +: 2];
        prs_r <= pwdata[cbt_pkg::PRS_LSB +: 3];
      end
      if (hit(paddr, cbt_pkg::IDX_BT_PHASE)) begin
        phase_segment_two_r <= pwdata[cbt_pkg::PHASE_SEGMENT_TWO_LSB +: 3];
        phase_segment_one_r <= pwdata[cbt_pkg::PHASE_SEGMENT_ONE_LSB +: 3];
        smp_r  <= pwdata[cbt_pkg::SMP_BIT];
      end
      if (hit(paddr, cbt_pkg::IDX_TMR_PRESC)) begin
        tdiv_r <= pwdata[7:0];
      end
      if (hit(paddr, cbt_pkg::IDX_EVT_MASK)) begin
        mask_r <= pwdata[1:0];
      end
    end
  end

  // Object status mirrors the sources; request and priority follow it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      obj_stat_r <= cbt_pkg::RST_OBJ_EN;
      obj_irq_r  <= 1'b0;
      top_obj_r  <= cbt_pkg::NO_OBJECT;
    end else begin
      obj_stat_r <= obj_irq_src;
      obj_irq_r  <= |(obj_stat_r & obj_en_r);
      top_obj_r  <= top_obj(obj_stat_r);
    end
  end

  // Sticky events, write one to clear; a set in the clear cycle wins
  always_comb begin
    evt_nxt = evt_r;
    if (wr_en && hit(paddr, cbt_pkg::IDX_EVT_STAT)) begin
      evt_nxt = evt_r & ~pwdata[1:0];
    end
    evt_nxt[cbt_pkg::EVT_WRAP] = evt_nxt[cbt_pkg::EVT_WRAP] | wrap_evt;
    evt_nxt[cbt_pkg::EVT_OBJ]  = evt_nxt[cbt_pkg::EVT_OBJ] | (|(obj_irq_src & ~obj_stat_r));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_r <= cbt_pkg::RST_EVT;
      irq_r <= 1'b0;
    end else begin
      evt_r <= evt_nxt;
      irq_r <= |(evt_r & mask_r);
    end
  end

  // Bus pin synchroniser and sample history; idle level is recessive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1     <= 1'b1;
      rx_s2     <= 1'b1;
      rx_prev   <= 1'b1;
      rx_hist_r <= 2'b11;
    end else begin
      rx_s1     <= rx_bus;
      rx_s2     <= rx_s1;
      rx_prev   <= rx_s2;
      rx_hist_r <= {rx_hist_r[0], rx_s2};
    end
  end

  // Quantum prescaler; compare with >= so a smaller rewrite cannot stall it
  assign tq_tick = ctrl_enable && (tq_cnt_r >= brp_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tq_cnt_r <= 6'h00;
    end else if (!ctrl_enable || tq_tick) begin
      tq_cnt_r <= 6'h00;
    end else begin
      tq_cnt_r <= tq_cnt_r + 6'h01;
    end
  end

  // Resync arithmetic: phase error in quanta since the sync segment
  assign sjw1      = {2'b00, sjw_r} + 4'h1;
  assign phase_err = (state_r == cbt_pkg::SEG_PROP) ? {1'b0, seg_cnt_r} + 5'h01 :
                     {2'b00, prs_r} + {1'b0, seg_cnt_r} + 5'h02;
  assign ext       = (phase_err < {1'b0, sjw1}) ? phase_err[3:0] : sjw1;
  assign ph2_left  = ph2_end_r - seg_cnt_r;
  assign resync_ok = ctrl_enable && rx_prev && !rx_s2 && !resynced_r &&
                     (state_r != cbt_pkg::SEG_SYNC);
  assign sample_now = (state_r == cbt_pkg::SEG_PH1) && tq_tick &&
                      (seg_cnt_r == ph1_end_r - 4'h1);

  // Bit segment machine; one resync per bit, edge takes priority over the tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= cbt_pkg::SEG_SYNC;
      seg_cnt_r  <= 4'h0;
      ph1_end_r  <= cbt_pkg::RST_SEG_END;
      ph2_end_r  <= cbt_pkg::RST_SEG_END;
      resynced_r <= 1'b0;
    end else if (!ctrl_enable) begin
      state_r    <= cbt_pkg::SEG_SYNC;
      seg_cnt_r  <= 4'h0;
      resynced_r <= 1'b0;
    end else begin
      if (tq_tick) begin
        unique case (state_r)
          cbt_pkg::SEG_SYNC: begin
            state_r    <= cbt_pkg::SEG_PROP;
            seg_cnt_r  <= 4'h0;
            ph1_end_r  <= {1'b0, phase_segment_one_r} + 4'h1;
            ph2_end_r  <= {1'b0, phase_segment_two_r} + 4'h1;
            resynced_r <= 1'b0;
          end
          cbt_pkg::SEG_PROP: begin
            if (seg_cnt_r == {1'b0, prs_r}) begin
              state_r   <= cbt_pkg::SEG_PH1;
              seg_cnt_r <= 4'h0;
            end else begin
              seg_cnt_r <= seg_cnt_r + 4'h1;
            end
          end
          cbt_pkg::SEG_PH1: begin
            if (seg_cnt_r == ph1_end_r - 4'h1) begin
              state_r   <= cbt_pkg::SEG_PH2;
              seg_cnt_r <= 4'h0;
            end else begin
              seg_cnt_r <= seg_cnt_r + 4'h1;
            end
          end
          cbt_pkg::SEG_PH2: begin
            if (seg_cnt_r == ph2_end_r - 4'h1) begin
              state_r   <= cbt_pkg::SEG_SYNC;
              seg_cnt_r <= 4'h0;
            end else begin
              seg_cnt_r <= seg_cnt_r + 4'h1;
            end
          end
        endcase
      end
      if (resync_ok) begin
        resynced_r <= 1'b1;
        if (state_r == cbt_pkg::SEG_PH2) begin
          // Positive field keeps the shortened segment non-empty
          if (ph2_left <= sjw1) begin
            state_r   <= cbt_pkg::SEG_PROP;
            seg_cnt_r <= 4'h0;
            ph1_end_r <= {1'b0, phase_segment_one_r} + 4'h1;
            ph2_end_r <= {1'b0, phase_segment_two_r} + 4'h1;
            resynced_r <= 1'b0;                         // Edge opened a new bit
          end else begin
            ph2_end_r <= ph2_end_r - sjw1;
          end
        end else begin
          ph1_end_r <= ph1_end_r + ext;
        end
      end
    end
  end

  // Vote over SP-2, SP-1 and SP; needs quanta longer than one clock
  assign majority = (rx_s2 & rx_hist_r[0]) | (rx_s2 & rx_hist_r[1]) |
                    (rx_hist_r[0] & rx_hist_r[1]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_pulse_r <= 1'b0;
      sampled_bit_r  <= 1'b1;
    end else begin
      sample_pulse_r <= sample_now;
      if (sample_now) begin
        sampled_bit_r <= smp_r ? majority : rx_s2;
      end
    end
  end

  // Timer divider: limit is divider*8+7, i.e. 8*(divider+1) clocks per step
  assign tmr_tick = ctrl_enable && (tdiv_cnt_r >= {tdiv_r, cbt_pkg::TMR_DIV_LOW});
  assign wrap_evt = tmr_tick && (timer_r == cbt_pkg::TMR_MAX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdiv_cnt_r <= 11'h000;
    end else if (!ctrl_enable || tmr_tick) begin
      tdiv_cnt_r <= 11'h000;
    end else begin
      tdiv_cnt_r <= tdiv_cnt_r + 11'h001;
    end
  end

  // Free-running timer and capture of it on the trigger strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_r <= cbt_pkg::RST_COUNT;
      capt_r  <= cbt_pkg::RST_COUNT;
    end else begin
      if (tmr_tick) begin
        timer_r <= timer_r + 16'h0001;
      end
      if (capture_strobe) begin
        capt_r <= timer_r;
      end
    end
  end

  // Helper gap counters for period checks; any register write clears their valid flags
  logic [6:0]  tq_gap_r;
  logic [11:0] tm_gap_r;
  logic        tq_valid_r;
  logic        tm_valid_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tq_gap_r   <= 7'h00;
      tm_gap_r   <= 12'h000;
      tq_valid_r <= 1'b0;
      tm_valid_r <= 1'b0;
    end else begin
      tq_gap_r   <= (tq_tick || !ctrl_enable) ? 7'h00 : tq_gap_r + 7'h01;
      tm_gap_r   <= (tmr_tick || !ctrl_enable) ? 12'h000 : tm_gap_r + 12'h001;
      tq_valid_r <= ctrl_enable && !wr_en && (tq_valid_r || tq_tick);
      tm_valid_r <= ctrl_enable && !wr_en && (tm_valid_r || tmr_tick);
    end
  end

  property p_obj_disabled;
    @(posedge pclk) disable iff (!presetn)
      ((obj_stat_r & obj_en_r) == 6'h00) |=> !obj_irq;
  endproperty
  a_obj_disabled: assert property (p_obj_disabled) else $error("masked object raised request");

  property p_stat_mirror;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> (obj_stat_r == $past(obj_irq_src));
  endproperty
  a_stat_mirror: assert property (p_stat_mirror) else $error("status does not follow source");

  property p_tq_period;
    @(posedge pclk) disable iff (!presetn)
      (tq_tick && tq_valid_r) |-> (tq_gap_r == {1'b0, brp_r});
  endproperty
  a_tq_period: assert property (p_tq_period) else $error("quantum period wrong");

  property p_ph2_shorten;
    @(posedge pclk) disable iff (!presetn)
      (resync_ok && state_r == cbt_pkg::SEG_PH2 && ph2_left > sjw1) |=>
        (ph2_end_r == $past(ph2_end_r) - $past(sjw1));
  endproperty
  a_ph2_shorten: assert property (p_ph2_shorten) else $error("phase two not shortened");

  property p_prop_len;
    @(posedge pclk) disable iff (!presetn)
      (state_r == cbt_pkg::SEG_PROP && tq_tick && !resync_ok) |=>
        ((state_r == cbt_pkg::SEG_PH1) == ($past(seg_cnt_r) == {1'b0, $past(prs_r)}));
  endproperty
  a_prop_len: assert property (p_prop_len) else $error("propagation length wrong");

  // Phase lengths reload at each bit start; a mid-bit rewrite of them only acts on the next bit
  property p_ph2_bound;
    @(posedge pclk) disable iff (!presetn)
      (tq_tick && state_r == cbt_pkg::SEG_SYNC) |=>
        (ph2_end_r == {1'b0, $past(phase_segment_two_r)} + 4'h1);
  endproperty
  a_ph2_bound: assert property (p_ph2_bound) else $error("phase two length not loaded");

  property p_ph1_bound;
    @(posedge pclk) disable iff (!presetn)
      (tq_tick && state_r == cbt_pkg::SEG_SYNC) |=>
        (ph1_end_r == {1'b0, $past(phase_segment_one_r)} + 4'h1);
  endproperty
  a_ph1_bound: assert property (p_ph1_bound) else $error("phase one length not loaded");

  property p_ph1_stretch;
    @(posedge pclk) disable iff (!presetn)
      (resync_ok && state_r != cbt_pkg::SEG_PH2) |=>
        (ph1_end_r > $past(ph1_end_r)) && (ph1_end_r <= $past(ph1_end_r) + $past(sjw1));
  endproperty
  a_ph1_stretch: assert property (p_ph1_stretch) else $error("stretch out of range");

  property p_single_sample;
    @(posedge pclk) disable iff (!presetn)
      (sample_now && !smp_r) |=> sample_pulse && (sampled_bit == $past(rx_s2));
  endproperty
  a_single_sample: assert property (p_single_sample) else $error("single sample wrong");

  property p_triple_sample;
    @(posedge pclk) disable iff (!presetn)
      (sample_now && smp_r) |=> (sampled_bit ==
        (($past(rx_s2) & $past(rx_s2, 2)) | ($past(rx_s2) & $past(rx_s2, 3)) |
         ($past(rx_s2, 2) & $past(rx_s2, 3))));
  endproperty
  a_triple_sample: assert property (p_triple_sample) else $error("majority vote wrong");

  property p_tmr_period;
    @(posedge pclk) disable iff (!presetn)
      (tmr_tick && tm_valid_r) |-> (tm_gap_r == {1'b0, tdiv_r, cbt_pkg::TMR_DIV_LOW});
  endproperty
  a_tmr_period: assert property (p_tmr_period) else $error("timer period wrong");

  property p_tmr_hold;
    @(posedge pclk) disable iff (!presetn)
      !ctrl_enable |=> $stable(timer_r);
  endproperty
  a_tmr_hold: assert property (p_tmr_hold) else $error("timer ran while disabled");

  property p_tmr_step;
    @(posedge pclk) disable iff (!presetn)
      tmr_tick |=> (timer_r == $past(timer_r) + 16'h0001);
  endproperty
  a_tmr_step: assert property (p_tmr_step) else $error("timer step wrong");

  property p_capture;
    @(posedge pclk) disable iff (!presetn)
      capture_strobe |=> (capt_r == $past(timer_r));
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      (tmr_tick && timer_r == cbt_pkg::TMR_MAX) |=> (timer_r == 16'h0000) && timer_wrap_flag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag not raised");

  property p_no_object;
    @(posedge pclk) disable iff (!presetn)
      (obj_stat_r == 6'h00) |=> (top_priority_object == cbt_pkg::NO_OBJECT);
  endproperty
  a_no_object: assert property (p_no_object) else $error("empty status not all ones");

  property p_obj_request;
    @(posedge pclk) disable iff (!presetn)
      ((obj_stat_r & obj_en_r) != 6'h00) |=> obj_irq;
  endproperty
  a_obj_request: assert property (p_obj_request) else $error("object request missing");

  c_ph2_restart: cover property (@(posedge pclk) disable iff (!presetn)
    resync_ok && state_r == cbt_pkg::SEG_PH2 && ph2_left <= sjw1);
  c_triple: cover property (@(posedge pclk) disable iff (!presetn) sample_now && smp_r);
  c_wrap: cover property (@(posedge pclk) disable iff (!presetn) wrap_evt);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));

endmodule // cbt_core

// ---- testbench/cbt_bus_node.sv ----
// Model of another bus node that can hold the bus dominant for a set time
`timescale 1ns/100ps
module cbt_bus_node (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       send,
  input  wire logic [7:0] dom_len,
  output logic            rx_bus
);
  logic [7:0] left_r;

  // Dominant while the count runs; recessive is the resting level of the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_r <= 8'h00;
    end else if (send) begin
      left_r <= dom_len;
    end else if (left_r != 8'h00) begin
      left_r <= left_r - 8'h01;
    end
  end
  assign rx_bus = (left_r == 8'h00);
endmodule // cbt_bus_node

// ---- testbench/cbt_bench.sv ----
// Self-checking bench for the CAN bit timing, interrupt mask and timer block
`timescale 1ns/100ps
module cbt_bench;
  typedef struct packed {logic [7:0] i; logic wr; logic [31:0] d, x; logic e;} cbt_row_t;
  logic        pclk, presetn, psel, penable, pwrite, ctrl_enable, capture_strobe, er;
  logic        pready, pslverr, obj_irq, timer_wrap_flag, sample_pulse, sampled_bit, irq;
  logic        rx_bus, send;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, gap;
  logic [3:0]  top_priority_object;
  logic [5:0]  obj_irq_src;
  logic [7:0]  dom_len;
  cbt_row_t    rows [12];
  int          n_errors, checked;
  int          cyc = 0;

  cbt_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ctrl_enable(ctrl_enable), .obj_irq_src(obj_irq_src),
    .rx_bus(rx_bus), .capture_strobe(capture_strobe), .obj_irq(obj_irq),
    .top_priority_object(top_priority_object), .timer_wrap_flag(timer_wrap_flag),
    .sample_pulse(sample_pulse), .sampled_bit(sampled_bit), .irq(irq));
  cbt_bus_node node (.pclk(pclk), .presetn(presetn), .send(send), .dom_len(dom_len),
    .rx_bus(rx_bus));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Free cycle count so capture strobes land a fixed distance apart
  always @(posedge pclk) cyc <= cyc + 1;

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One APB transfer; index times four gives the byte address
  task automatic apb(logic [7:0] i, logic wr, logic [31:0] d);
    int k;
    k = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {2'b00, i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 40) begin
      n_errors++;
      results();
    end
  endtask
  // Bit period as distance between sample pulses, after settling one bit
  task automatic period(logic [31:0] x);
    int p;
    for (int j = 0; j < 3; j++) begin
      p = 0;
      do begin
        @(posedge pclk);
        p++;
      end while (sample_pulse !== 1'b1 && p < 99);
      if (p >= 99) begin
        n_errors++;
        results();
      end
    end
    chk(p, x);
  endtask
  // Timer advance between two captures exactly 160 clocks apart
  task automatic capt_gap();
    int t0;
    t0 = cyc;
    capture_strobe <= 1'b1;
    @(posedge pclk);
    capture_strobe <= 1'b0;
    apb(8'hE8, 1'b0, 32'h0);
    gap = rd;
    while (cyc < t0 + 160) begin
      @(posedge pclk);
    end
    capture_strobe <= 1'b1;
    @(posedge pclk);
    capture_strobe <= 1'b0;
    apb(8'hE8, 1'b0, 32'h0);
    gap = rd - gap;
  endtask

  initial begin
    psel           = 1'b0;
    penable        = 1'b0;
    pwrite         = 1'b0;
    paddr          = 12'h000;
    pwdata         = 32'h0000_0000;
    ctrl_enable    = 1'b0;
    capture_strobe = 1'b0;
    obj_irq_src    = 6'h00;
    send           = 1'b0;
    dom_len        = 8'h00;
    presetn        = 1'b0;
    n_errors       = 0;
    checked        = 0;
    rows = '{'{8'hDE, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'hDE, 1'b1, 32'hC, 32'hC, 1'b0},
      '{8'hE0, 1'b1, 32'h3F, 32'h0, 1'b0}, '{8'hE2, 1'b1, 32'h7E, 32'h7E, 1'b0},
      '{8'hE3, 1'b1, 32'h6E, 32'h6E, 1'b0}, '{8'hE4, 1'b1, 32'h7E, 32'h7E, 1'b0},
      '{8'hE5, 1'b1, 32'hFF, 32'hFF, 1'b0}, '{8'hE6, 1'b1, 32'hFFFF, 32'h0, 1'b0},
      '{8'hE8, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'hF2, 1'b0, 32'h0, 32'hF, 1'b0},
      '{8'hEA, 1'b0, 32'h0, 32'h0, 1'b1}, '{8'hF1, 1'b1, 32'h3, 32'h3, 1'b0}};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(top_priority_object, 4'hF);
    // Register table: reset values, access kinds, unmapped place
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        apb(rows[i].i, 1'b1, rows[i].d);
      end
      apb(rows[i].i, 1'b0, 32'h0);
      chk(rd, rows[i].x);
      chk(er, rows[i].e);
    end
    // Objects 0 and 5 pending, only 2 and 3 enabled
    obj_irq_src <= 6'h21;
    repeat (3) @(posedge pclk);
    chk(obj_irq, 1'b0);
    chk(top_priority_object, 4'h0);
    chk(irq, 1'b1);
    apb(8'hE0, 1'b0, 32'h0);
    chk(rd, 32'h21);
    apb(8'hF0, 1'b1, 32'h2);
    @(posedge pclk);
    chk(irq, 1'b0);
    apb(8'hDE, 1'b1, 32'h20);
    @(posedge pclk);
    chk(obj_irq, 1'b1);
    obj_irq_src <= 6'h00;
    repeat (3) @(posedge pclk);
    chk(top_priority_object, 4'hF);
    chk(obj_irq, 1'b0);
    // Timer at 16 clocks a step, then frozen while disabled
    apb(8'hE5, 1'b1, 32'h1);
    ctrl_enable <= 1'b1;
    capt_gap();
    chk(gap, 32'hA);
    // Tq 2 clocks, bit 1+1+2+2 quanta; phase two within phase one
    apb(8'hE2, 1'b1, 32'h2);
    apb(8'hE3, 1'b0, 32'h0);
    chk(rd, 32'h6E);
    apb(8'hE3, 1'b1, 32'h0);
    apb(8'hE4, 1'b1, 32'h13);
    period(12);
    chk(sampled_bit, 1'b1);
    dom_len <= 8'h3C;
    send    <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    repeat (40) @(posedge pclk);
    chk(sampled_bit, 1'b0);
    repeat (60) @(posedge pclk);
    chk(sampled_bit, 1'b1);
    // Tq one clock; triple sampling goes off before the prescale reaches zero
    apb(8'hE4, 1'b1, 32'h26);
    apb(8'hE2, 1'b1, 32'h0);
    apb(8'hE3, 1'b1, 32'h4);
    period(11);
    ctrl_enable <= 1'b0;
    capt_gap();
    chk(gap, 32'h0);
    chk(timer_wrap_flag, 1'b0);
    // Reset in mid-run brings configuration back to its reset values
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(8'hDE, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(8'hE2, 1'b0, 32'h0);
    chk(rd, 32'h0);
    results();
  end
endmodule // cbt_bench
